// ---- shared/ctc_map.svh ----
// constants for the tag comparator controller
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH
`define CTC_INDEX_W      14
`define CTC_TAG_W        5
`define CTC_CLK_NS       25
// pulse, settle and access figures in ns, turned into cycles below
`define CTC_WR_LOW_NS    12
`define CTC_RST_LOW_NS   80
`define CTC_SETTLE_NS    20
`define CTC_ACCESS_NS    25
`define CTC_CYC_UP(ns)   ((((ns) + `CTC_CLK_NS - 1) / `CTC_CLK_NS) + 1)
`define CTC_WR_CYC       `CTC_CYC_UP(`CTC_WR_LOW_NS)
`define CTC_RST_CYC      `CTC_CYC_UP(`CTC_RST_LOW_NS)
`define CTC_SETTLE_CYC   `CTC_CYC_UP(`CTC_SETTLE_NS)
`define CTC_ACCESS_CYC   `CTC_CYC_UP(`CTC_ACCESS_NS)
`endif

// ---- shared/ctc_pkg.sv ----
// types for the tag comparator controller
`default_nettype none
package ctc_pkg;
	typedef enum logic [2:0] {
		CTC_OP_COMPARE = 3'h0,
		CTC_OP_WRITE   = 3'h1,
		CTC_OP_READ    = 3'h2,
		CTC_OP_CLEAR   = 3'h3
	} ctc_op_t;

	typedef struct packed {
		ctc_op_t     op;
		logic [13:0] index;
		logic [4:0]  tag;
	} ctc_req_t;

	typedef struct packed {
		logic       hit;
		logic [4:0] tag;
	} ctc_rsp_t;

	typedef struct packed {
		logic chip_enable_n;
		logic store_n;
		logic fetch_out_n;
		logic clear_all_n;
	} ctc_ctl_t;
endpackage
`default_nettype wire

// ---- design/ctc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ctc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule // ctc_sync
`default_nettype wire

// ---- design/ctc_ctrl.sv ----
// controller that drives the cache tag comparator through its pins
// Function
// - one tag line may be valid bit
// - one valid bit serves whole group
// - index held stable through write
// - index fed from registers
// - same index across wide groups
// - ignore hit until settled after write
`timescale 1ns/1ps
`default_nettype none
`include "ctc_map.svh"
module ctc_ctrl
	import ctc_pkg::*;
#(
	parameter int  INDEX_W   = `CTC_INDEX_W,
	parameter int  TAG_W     = `CTC_TAG_W,
	parameter bit  VALID_BIT = 1'b1,
	parameter int  VALID_POS = TAG_W - 1
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire ctc_req_t           req_i,
	input  wire logic               req_valid_i,
	output logic                    req_ready_o,
	output ctc_rsp_t                rsp_o,
	output logic                    rsp_valid_o,
	output logic [INDEX_W-1:0]      index_in_o,
	output ctc_ctl_t                ctl_o,
	output logic [TAG_W-1:0]        tag_bus_o,
	output logic [TAG_W-1:0]        tag_bus_oe_o,
	input  wire logic [TAG_W-1:0]   tag_bus_i,
	input  wire logic               tag_hit_i
);
	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	// counts are fixed for a 25 ns clock; a faster clock needs new figures
	localparam int WR_CYC     = `CTC_WR_CYC;
	localparam int RST_CYC    = `CTC_RST_CYC;
	localparam int SETTLE_CYC = `CTC_SETTLE_CYC;
	// two extra cycles cover the synchroniser on the returned pins
	localparam int ACC_CYC    = `CTC_ACCESS_CYC + 2;
	localparam int CNT_W      = 8;

	// ----------------------------------------
	// state encoding
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_SETUP  = 6'b000010,
		ST_PULSE  = 6'b000100,
		ST_SETTLE = 6'b001000,
		ST_SAMPLE = 6'b010000,
		ST_DONE   = 6'b100000
	} ctc_state_t;

	// ----------------------------------------
	// returned pins
	// ----------------------------------------
	logic [TAG_W:0] pins_sync;

	ctc_sync #(
		.W(TAG_W + 1)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i  ({tag_hit_i, tag_bus_i}),
		.q_o  (pins_sync)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	ctc_state_t         state_q, state_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;
	ctc_op_t            op_q, op_d;
	logic [INDEX_W-1:0] index_q, index_d;
	logic [TAG_W-1:0]   tag_q, tag_d;
	ctc_ctl_t           ctl_q, ctl_d;
	logic               drive_q, drive_d;
	ctc_rsp_t           rsp_q, rsp_d;
	logic               rsp_valid_q, rsp_valid_d;
	logic [TAG_W-1:0]   tag_eff;

	// a constant-high valid line keeps cleared entries from hitting
	always_comb begin
		tag_eff = req_i.tag[TAG_W-1:0];
		if (VALID_BIT) begin
			tag_eff[VALID_POS] = 1'b1;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		op_d        = op_q;
		index_d     = index_q;
		tag_d       = tag_q;
		ctl_d       = ctl_q;
		drive_d     = drive_q;
		rsp_d       = rsp_q;
		rsp_valid_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (req_valid_i) begin
					op_d    = req_i.op;
					index_d = req_i.index[INDEX_W-1:0];
					tag_d   = tag_eff;
					cnt_d   = '0;
					state_d = ST_SETUP;
					if (req_i.op == CTC_OP_CLEAR) begin
						// clear runs alone, all other strobes idle
						ctl_d   = '{chip_enable_n: 1'b1, store_n: 1'b1, fetch_out_n: 1'b1, clear_all_n: 1'b0};
						drive_d = 1'b0;
						state_d = ST_PULSE;
					end else begin
						ctl_d.chip_enable_n = 1'b0;
						ctl_d.fetch_out_n   = (req_i.op != CTC_OP_READ);
						drive_d             = (req_i.op != CTC_OP_READ);
					end
				end
			end
			ST_SETUP: begin
				// index settles one cycle before store falls
				if (op_q == CTC_OP_WRITE) begin
					ctl_d.store_n = 1'b0;
					state_d       = ST_PULSE;
				end else begin
					state_d = ST_SAMPLE;
				end
				cnt_d = '0;
			end
			ST_PULSE: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(((op_q == CTC_OP_CLEAR) ? RST_CYC : WR_CYC) - 1)) begin
					ctl_d.store_n     = 1'b1;
					ctl_d.clear_all_n = 1'b1;
					cnt_d             = '0;
					state_d           = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				// index and data stay put while hit recovers
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
					ctl_d.chip_enable_n = 1'b1;
					drive_d             = 1'b0;
					rsp_d.hit           = 1'b1;
					rsp_d.tag           = tag_q;
					state_d             = ST_DONE;
				end
			end
			ST_SAMPLE: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(ACC_CYC - 1)) begin
					rsp_d.hit = pins_sync[TAG_W];
					rsp_d.tag = (op_q == CTC_OP_READ) ? pins_sync[TAG_W-1:0] : tag_q;
					ctl_d.chip_enable_n = 1'b1;
					ctl_d.fetch_out_n   = 1'b1;
					drive_d             = 1'b0;
					state_d             = ST_DONE;
				end
			end
			ST_DONE: begin
				rsp_valid_d = 1'b1;
				state_d     = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q     <= ST_IDLE;
			cnt_q       <= '0;
			op_q        <= CTC_OP_COMPARE;
			index_q     <= '0;
			tag_q       <= '0;
			ctl_q       <= '{chip_enable_n: 1'b1, store_n: 1'b1, fetch_out_n: 1'b1, clear_all_n: 1'b1};
			drive_q     <= 1'b0;
			rsp_q       <= '0;
			rsp_valid_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			op_q        <= op_d;
			index_q     <= index_d;
			tag_q       <= tag_d;
			ctl_q       <= ctl_d;
			drive_q     <= drive_d;
			rsp_q       <= rsp_d;
			rsp_valid_q <= rsp_valid_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign req_ready_o  = (state_q == ST_IDLE);
	assign rsp_o        = rsp_q;
	assign rsp_valid_o  = rsp_valid_q;
	assign index_in_o   = index_q;
	assign ctl_o        = ctl_q;
	assign tag_bus_o    = tag_q;
	assign tag_bus_oe_o = {TAG_W{drive_q}};
endmodule // ctc_ctrl
`default_nettype wire

// ---- verif/ctc_ctrl_props.sv ----
// checker on the pins and handshake of the tag comparator controller
`timescale 1ns/1ps
`default_nettype none
module ctc_ctrl_props
	import ctc_pkg::*;
#(
	parameter int INDEX_W   = 14,
	parameter int TAG_W     = 5,
	parameter int VALID_POS = 4
) (
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               req_valid_i,
	input wire logic               req_ready_o,
	input wire logic               rsp_valid_o,
	input wire logic [INDEX_W-1:0] index_in_o,
	input wire ctc_ctl_t           ctl_o,
	input wire logic [TAG_W-1:0]   tag_bus_o,
	input wire logic [TAG_W-1:0]   tag_bus_oe_o
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; req_valid_i && req_ready_o; endsequence
	sequence s_answer; ##[5:10] rsp_valid_o; endsequence
	property p_take; s_take |=> !req_ready_o; endproperty
	property p_answer; s_take |-> s_answer; endproperty
	property p_pulse; rsp_valid_o |=> !rsp_valid_o; endproperty
	property p_settle; $rose(ctl_o.store_n) |-> !rsp_valid_o [*2]; endproperty
	property p_idx; (!ctl_o.store_n || $rose(ctl_o.store_n)) |-> $stable(index_in_o); endproperty
	property p_valid; |tag_bus_oe_o |-> tag_bus_o[VALID_POS]; endproperty
	property p_read; !ctl_o.fetch_out_n |-> tag_bus_oe_o == '0 && ctl_o.store_n; endproperty
	property p_write; !ctl_o.store_n |-> !ctl_o.chip_enable_n && tag_bus_oe_o == '1; endproperty
	property p_clear; !ctl_o.clear_all_n |-> ctl_o.store_n && ctl_o.fetch_out_n && tag_bus_oe_o == '0; endproperty
	property p_idle; ctl_o.chip_enable_n && ctl_o.clear_all_n |-> tag_bus_oe_o == '0; endproperty
	a_take: assert property (p_take)
		else $error("ready high after take");
	a_answer: assert property (p_answer)
		else $error("answer late");
	a_pulse: assert property (p_pulse)
		else $error("answer pulse too long");
	a_settle: assert property (p_settle)
		else $error("hit trusted before settle");
	a_idx: assert property (p_idx)
		else $error("index moved during write");
	a_valid: assert property (p_valid)
		else $error("valid line low");
	a_read: assert property (p_read)
		else $error("bus driven while reading");
	a_write: assert property (p_write)
		else $error("write without select or drive");
	a_clear: assert property (p_clear)
		else $error("activity during clear");
	a_idle: assert property (p_idle)
		else $error("bus driven while deselected");
endmodule // ctc_ctrl_props
bind ctc_ctrl ctc_ctrl_props #(.INDEX_W(INDEX_W), .TAG_W(TAG_W), .VALID_POS(VALID_POS)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .index_in_o(index_in_o), .ctl_o(ctl_o),
	.tag_bus_o(tag_bus_o), .tag_bus_oe_o(tag_bus_oe_o));
`default_nettype wire

// ---- verif/ctc_tag_model.sv ----
// behavioural tag store and comparator on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module ctc_tag_model
	import ctc_pkg::*;
(
	input wire logic [13:0] index_in_i,
	input wire ctc_ctl_t    ctl_i,
	input wire logic [4:0]  tag_bus_i,
	output logic [4:0]      tag_bus_o,
	output logic            tag_bus_oe_o,
	output logic            tag_hit_o
);
	logic [4:0] mem [0:16383];
	logic       sel;
	// clear wins over any write level
	always @(ctl_i, index_in_i, tag_bus_i) begin
		if (!ctl_i.clear_all_n) foreach (mem[i]) mem[i] = 5'h00;
		else if (!ctl_i.chip_enable_n && !ctl_i.store_n) mem[index_in_i] = tag_bus_i;
	end
	assign sel = ctl_i.clear_all_n && !ctl_i.chip_enable_n;
	assign tag_bus_oe_o = sel && ctl_i.store_n && !ctl_i.fetch_out_n;
	assign tag_bus_o = mem[index_in_i];
	assign tag_hit_o = !sel || !ctl_i.store_n || !ctl_i.fetch_out_n || mem[index_in_i] == tag_bus_i;
endmodule // ctc_tag_model
`default_nettype wire

// ---- verif/ctc_ctrl_tb.sv ----
// self-checking bench for the tag comparator controller
`timescale 1ns/1ps
`default_nettype none
module ctc_ctrl_tb;
	import ctc_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_ready_o, rsp_valid_o, m_oe, hit;
	ctc_req_t req_i = '0;
	ctc_rsp_t rsp_o;
	ctc_ctl_t ctl_o;
	logic [13:0] idx;
	logic [4:0] d_tag, d_oe, m_tag, bus_w, flt = 5'h15;
	int n_mismatch = 0, tests_run = 0;
	always #12.5 clk_i = ~clk_i;
	// undriven lines toggle so a stale value never passes
	always @(posedge clk_i) flt <= ~flt;
	always_comb for (int i = 0; i < 5; i++) bus_w[i] = d_oe[i] ? d_tag[i] : (m_oe ? m_tag[i] : flt[i]);
	ctc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o), .index_in_o(idx),
		.ctl_o(ctl_o), .tag_bus_o(d_tag), .tag_bus_oe_o(d_oe), .tag_bus_i(bus_w), .tag_hit_i(hit));
	ctc_tag_model u_dev (.index_in_i(idx), .ctl_i(ctl_o), .tag_bus_i(bus_w), .tag_bus_o(m_tag),
		.tag_bus_oe_o(m_oe), .tag_hit_o(hit));
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic op(input ctc_op_t o, input logic [13:0] ix, input logic [4:0] tg);
		int n;
		@(posedge clk_i);
		req_i <= '{op: o, index: ix, tag: tg};
		req_valid_i <= 1'b1;
		do @(negedge clk_i); while (req_ready_o !== 1'b1);
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		for (n = 0; n < 20 && rsp_valid_o !== 1'b1; n++) @(negedge clk_i);
		chk("answer", 5'h01, {4'h0, rsp_valid_o});
	endtask
	task automatic t_clear;
		op(CTC_OP_CLEAR, 14'h0000, 5'h00);
		chk("clear hit", 5'h01, {4'h0, rsp_o.hit});
		op(CTC_OP_COMPARE, 14'h0005, 5'h00);
		chk("unwritten hit", 5'h00, {4'h0, rsp_o.hit});
		op(CTC_OP_READ, 14'h0005, 5'h00);
		chk("cleared tag", 5'h00, rsp_o.tag);
	endtask
	task automatic t_write;
		op(CTC_OP_WRITE, 14'h3FFF, 5'h0A);
		chk("write hit", 5'h01, {4'h0, rsp_o.hit});
		op(CTC_OP_COMPARE, 14'h3FFF, 5'h0A);
		chk("equal hit", 5'h01, {4'h0, rsp_o.hit});
		op(CTC_OP_COMPARE, 14'h3FFF, 5'h0B);
		chk("unequal hit", 5'h00, {4'h0, rsp_o.hit});
		op(CTC_OP_READ, 14'h3FFF, 5'h00);
		chk("read tag", 5'h1A, rsp_o.tag);
	endtask
	task automatic t_b2b;
		op(CTC_OP_WRITE, 14'h0000, 5'h03);
		op(CTC_OP_WRITE, 14'h0001, 5'h0C);
		op(CTC_OP_READ, 14'h0000, 5'h00);
		chk("tag 0", 5'h13, rsp_o.tag);
		op(CTC_OP_READ, 14'h0001, 5'h00);
		chk("tag 1", 5'h1C, rsp_o.tag);
	endtask
	task automatic t_reclear;
		op(CTC_OP_CLEAR, 14'h0000, 5'h00);
		op(CTC_OP_READ, 14'h3FFF, 5'h00);
		chk("recleared tag", 5'h00, rsp_o.tag);
		op(CTC_OP_COMPARE, 14'h0001, 5'h0C);
		chk("recleared hit", 5'h00, {4'h0, rsp_o.hit});
	endtask
	task automatic t_reset;
		@(posedge clk_i);
		req_i <= '{op: CTC_OP_WRITE, index: 14'h0002, tag: 5'h05};
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		// reset lands while the store strobe is low
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b1;
		@(negedge clk_i);
		chk("reset strobes", 5'h0F, {1'b0, ctl_o});
		chk("reset drive", 5'h00, d_oe);
		chk("reset answer", 5'h00, {4'h0, rsp_valid_o});
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("ready after reset", 5'h01, {4'h0, req_ready_o});
		op(CTC_OP_WRITE, 14'h0002, 5'h06);
		op(CTC_OP_COMPARE, 14'h0002, 5'h06);
		chk("hit after reset", 5'h01, {4'h0, rsp_o.hit});
	endtask
	initial begin
		#50000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_clear();
		t_write();
		t_b2b();
		t_reclear();
		t_reset();
		complete_run();
	end
endmodule // ctc_ctrl_tb
`default_nettype wire
